// *** include/boot_map_defs.svh ***
// Purpose: offsets, field positions, reset values and map bounds for the boot map decoder
// Assumes: 16-bit byte addresses, 8-bit data
// Notes:   definitions only
`ifndef BOOT_MAP_DEFS_SVH
`define BOOT_MAP_DEFS_SVH

// ==========================================================================
// registers
`define BM_CTRL_ADDR        16'h0fd0
`define BM_COMMIT_ADDR      16'h0fd1
`define BM_CTRL_RESET       8'h40
`define BM_COMMIT_CODE      8'hd5
`define BM_ENABLE_BIT       4

// ==========================================================================
// memory map
`define BOOT_LO             16'h1000
`define BOOT_HI             16'h17ff
`define BOOT_ABSENT_DATA    8'hff
`define FLASH_CODE_LO       16'h8000
`define FLASH_LO            16'hc000
`define FLASH_HI            16'hffff
`define SFR1_LO             16'h0000
`define SFR1_HI             16'h003f
`define SFR2_LO             16'h0f00
`define SFR2_HI             16'h0fff
`define SFR3_LO             16'h0e40
`define SFR3_HI             16'h0eff

// ==========================================================================
// vectors
`define VEC_RESET           16'hfffe
`define VEC_SWI             16'hfffc
`define VEC_WDT             16'hfff8
`define VEC_WAKEUP          16'hfff6
`define VEC_TBT             16'hfff4
`define VEC_VOLT            16'hffec
`define VEC_ADC             16'hffea
`define VEC_RTC             16'hffe8
`define VEC_T8C0            16'hffe6
`define VEC_T8C1            16'hffe4
`define VEC_T16A0           16'hffe2
`define VEC_EXT0            16'hffde
`define VEC_EXT1            16'hffdc
`define VEC_SER1RX          16'hffd2
`define VEC_SER1TX          16'hffd0
`define VEC_T8C2            16'hffce
`define VEC_T8C3            16'hffcc

`define NUM_IRQ             16

`endif

// *** include/boot_map_pkg.sv ***
// Purpose: shared types for the boot map decoder
// Assumes: nothing
// Notes:   constants live in boot_map_defs.svh
package boot_map_pkg;

    // ======================================================================
    // decode target of one access
    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_SFR,
        TGT_BOOT,
        TGT_FLASH,
        TGT_SWI,
        TGT_ABSENT
    } target_t;

endpackage

// *** verilog/vector_select.sv ***
// Purpose: picks the highest-priority pending, enabled interrupt and gives its entry
// Assumes: request index 0 has the highest priority
// Notes:   purely combinational, sampled by the caller
`timescale 1ns/1ps
`include "boot_map_defs.svh"

module vector_select #(
    parameter int NUM = `NUM_IRQ
) (
    input  wire logic [NUM-1:0] irqPending,
    input  wire logic [NUM-1:0] irqEnable,
    input  wire logic           stackFull,
    output logic                hit,
    output logic [15:0]         entry
);

    // ======================================================================
    // vector table
    localparam logic [15:0] TABLE [16] = '{
        `VEC_SWI, `VEC_WDT, `VEC_WAKEUP, `VEC_TBT,
        `VEC_VOLT, `VEC_ADC, `VEC_RTC, `VEC_T8C0,
        `VEC_T8C1, `VEC_T16A0, `VEC_EXT0, `VEC_EXT1,
        `VEC_SER1RX, `VEC_SER1TX, `VEC_T8C2, `VEC_T8C3
    };

    initial begin
        if (NUM != 16) begin
            $error("vector_select supports exactly 16 sources");
        end
    end

    // ======================================================================
    // priority pick, gated by enable and stack space
    always_comb begin
        hit   = 1'b0;
        entry = 16'h0000;
        for (int i = NUM - 1; i >= 0; i--) begin
            if (irqPending[i] && irqEnable[i] && !stackFull) begin
                hit   = 1'b1;
                entry = TABLE[i];
            end
        end
    end

endmodule // vector_select

// *** verilog/boot_map_decode.sv ***
// Purpose: boot ROM mapping control, code/data map decode and vector supply
// Assumes: CPU core on the same clock; one access per cycle
// Notes:   all outputs registered, so decode answers one cycle after request
`timescale 1ns/1ps
`include "boot_map_defs.svh"

module boot_map_decode #(
    parameter int  NUM_IRQ   = `NUM_IRQ,
    parameter bit  BIG_FLASH = 1'b0
) (
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    input  wire logic               serialProgMode,
    input  wire logic               accValid,
    input  wire logic               accFetch,
    input  wire logic               accWrite,
    input  wire logic [15:0]        accAddr,
    input  wire logic [7:0]         accWdata,
    input  wire logic [7:0]         bootRdata,
    input  wire logic [7:0]         flashRdata,
    input  wire logic [NUM_IRQ-1:0] irqPending,
    input  wire logic [NUM_IRQ-1:0] irqEnable,
    input  wire logic               stackFull,
    input  wire logic               resetEntryReq,
    output logic [12:0]             bootAddr,
    output logic [13:0]             flashAddr,
    output logic                    selSfr,
    output logic                    selBoot,
    output logic                    selFlash,
    output logic                    rdataValid,
    output logic [7:0]              rdata,
    output logic [7:0]              mapEffective,
    output logic                    bootMapped,
    output logic                    vectorValid,
    output logic [15:0]             vectorAddr
);

    // ======================================================================
    // elaboration checks
    initial begin
        if (NUM_IRQ != 16) begin
            $error("boot_map_decode needs 16 interrupt sources");
        end
    end

    localparam logic [7:0] SWI_OPCODE = 8'hff;

    // ======================================================================
    // boot map control: holding copy and effective copy
    logic [7:0] holdCopy;
    logic [7:0] effCopy;
    logic [7:0] next_holdCopy;
    logic [7:0] next_effCopy;

    logic ctrlWrite;
    logic commitWrite;

    assign ctrlWrite   = accValid && accWrite && !accFetch && (accAddr == `BM_CTRL_ADDR);
    assign commitWrite = accValid && accWrite && !accFetch && (accAddr == `BM_COMMIT_ADDR);

    always_comb begin
        next_holdCopy = holdCopy;
        next_effCopy  = effCopy;
        if (ctrlWrite) begin
            next_holdCopy = accWdata;
        end
        if (commitWrite && accWdata == `BM_COMMIT_CODE) begin
            next_effCopy = holdCopy;
        end
        // any other key value falls through with both copies untouched
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            holdCopy <= `BM_CTRL_RESET;
            effCopy  <= `BM_CTRL_RESET;
        end else begin
            holdCopy <= next_holdCopy;
            effCopy  <= next_effCopy;
        end
    end

    logic mapOn;
    assign mapOn = effCopy[`BM_ENABLE_BIT];

    // ======================================================================
    // address decode
    boot_map_pkg::target_t tgt;

    logic inBoot;
    logic inSfr;
    logic inFlash;

    assign inBoot  = (accAddr >= `BOOT_LO) && (accAddr <= `BOOT_HI);
    assign inSfr   = (accAddr <= `SFR1_HI)
                  || ((accAddr >= `SFR2_LO) && (accAddr <= `SFR2_HI))
                  || ((accAddr >= `SFR3_LO) && (accAddr <= `SFR3_HI));
    // whole upper half decodes to flash; only 0xc000 up is populated,
    // so the low 14 bits address the array and lower addresses alias
    assign inFlash = accAddr >= `FLASH_CODE_LO;

    always_comb begin
        tgt = boot_map_pkg::TGT_NONE;
        if (inBoot) begin
            if (mapOn) begin
                tgt = boot_map_pkg::TGT_BOOT;
            end else if (accFetch) begin
                // small parts have nothing here, so the core traps
                tgt = BIG_FLASH ? boot_map_pkg::TGT_FLASH : boot_map_pkg::TGT_SWI;
            end else begin
                tgt = boot_map_pkg::TGT_ABSENT;
            end
        end else if (inFlash) begin
            tgt = boot_map_pkg::TGT_FLASH;
        end else if (inSfr && !accFetch) begin
            tgt = boot_map_pkg::TGT_SFR;
        end
    end

    // ======================================================================
    // registered access answer
    logic [12:0] next_bootAddr;
    logic [13:0] next_flashAddr;
    logic        next_selSfr;
    logic        next_selBoot;
    logic        next_selFlash;
    logic        next_rdataValid;
    logic [7:0]  next_rdata;

    always_comb begin
        next_bootAddr   = bootAddr;
        next_flashAddr  = flashAddr;
        next_selSfr     = 1'b0;
        next_selBoot    = 1'b0;
        next_selFlash   = 1'b0;
        next_rdataValid = accValid && !accWrite;
        next_rdata      = 8'h00;
        if (accValid) begin
            // outside serial prom mode the top address bit is held low
            next_bootAddr  = {serialProgMode & accAddr[11], accAddr[11:0]};
            next_flashAddr = accAddr[13:0];
            case (tgt)
                boot_map_pkg::TGT_BOOT:   next_selBoot  = 1'b1;
                boot_map_pkg::TGT_FLASH:  next_selFlash = 1'b1;
                boot_map_pkg::TGT_SFR:    next_selSfr   = 1'b1;
                boot_map_pkg::TGT_SWI:    next_rdata    = SWI_OPCODE;
                boot_map_pkg::TGT_ABSENT: next_rdata    = `BOOT_ABSENT_DATA;
                default:                  next_rdata    = 8'h00;
            endcase
            if (!accWrite && !accFetch) begin
                if (accAddr == `BM_CTRL_ADDR) begin
                    next_rdata = holdCopy;
                end else if (accAddr == `BM_COMMIT_ADDR) begin
                    next_rdata = effCopy;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bootAddr   <= 13'h0000;
            flashAddr  <= 14'h0000;
            selSfr     <= 1'b0;
            selBoot    <= 1'b0;
            selFlash   <= 1'b0;
            rdataValid <= 1'b0;
            rdata      <= 8'h00;
        end else begin
            bootAddr   <= next_bootAddr;
            flashAddr  <= next_flashAddr;
            selSfr     <= next_selSfr;
            selBoot    <= next_selBoot;
            selFlash   <= next_selFlash;
            rdataValid <= next_rdataValid;
            rdata      <= next_rdata;
        end
    end

    // ======================================================================
    // mapping status
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mapEffective <= `BM_CTRL_RESET;
            bootMapped   <= 1'b0;
        end else begin
            mapEffective <= next_effCopy;
            bootMapped   <= next_effCopy[`BM_ENABLE_BIT];
        end
    end

    // ======================================================================
    // vector supply; reset entry outranks every interrupt
    logic        irqHit;
    logic [15:0] irqEntry;
    logic        next_vectorValid;
    logic [15:0] next_vectorAddr;

    vector_select #(
        .NUM        (NUM_IRQ)
    ) u_vector_select (
        .irqPending (irqPending),
        .irqEnable  (irqEnable),
        .stackFull  (stackFull),
        .hit        (irqHit),
        .entry      (irqEntry)
    );

    always_comb begin
        next_vectorValid = irqHit;
        next_vectorAddr  = irqEntry;
        if (resetEntryReq) begin
            next_vectorValid = 1'b1;
            next_vectorAddr  = `VEC_RESET;
        end
    end

    // the reset entry is also shown during reset so the core starts there
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            vectorValid <= 1'b1;
            vectorAddr  <= `VEC_RESET;
        end else begin
            vectorValid <= next_vectorValid;
            vectorAddr  <= next_vectorAddr;
        end
    end

endmodule // boot_map_decode

// *** sim/boot_map_decode_asserts.sv ***
// Purpose: port-level checks of the boot map decoder
// Assumes: one clock, async active-low reset
// Notes:   holding copy mirrored in helper logic
`timescale 1ns/1ps
`include "boot_map_defs.svh"

// ====================
// checker
module boot_map_decode_asserts #(
    parameter bit BIG_FLASH = 1'b0
) (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        serialProgMode,
    input wire logic        accValid,
    input wire logic        accFetch,
    input wire logic        accWrite,
    input wire logic [15:0] accAddr,
    input wire logic [7:0]  accWdata,
    input wire logic        stackFull,
    input wire logic        resetEntryReq,
    input wire logic [12:0] bootAddr,
    input wire logic [13:0] flashAddr,
    input wire logic        selSfr,
    input wire logic        selBoot,
    input wire logic        selFlash,
    input wire logic        rdataValid,
    input wire logic [7:0]  rdata,
    input wire logic [7:0]  mapEffective,
    input wire logic        bootMapped,
    input wire logic        vectorValid,
    input wire logic [15:0] vectorAddr
);
    logic [7:0]  hold;
    logic [7:0]  next_hold;
    logic        wr;
    logic        rd;
    logic        inBoot;
    logic        key;
    logic        special_function_regs;
    logic [12:0] bootExp;
    logic [13:0] flashExp;
    assign wr = accValid && !accFetch && accWrite;
    assign rd = accValid && !accWrite;
    assign inBoot = accAddr >= `BOOT_LO && accAddr <= `BOOT_HI;
    assign key = wr && accAddr == `BM_COMMIT_ADDR;
    // only the lowest 2 Kbytes of boot content are ever addressed
    assign bootExp = {2'b00, accAddr[10:0]};
    assign special_function_regs = accAddr <= `SFR1_HI || (accAddr >= `SFR2_LO && accAddr <= `SFR2_HI)
              || (accAddr >= `SFR3_LO && accAddr <= `SFR3_HI);
    assign flashExp = accAddr[13:0];
    always_comb begin
        next_hold = hold;
        if (wr && accAddr == `BM_CTRL_ADDR) next_hold = accWdata;
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) hold <= `BM_CTRL_RESET;
        else hold <= next_hold;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_reset_unmapped: assert property ($rose(rst_b) |-> !bootMapped)
        else $error("boot rom mapped after reset");
    a_commit_apply: assert property (key && accWdata == `BM_COMMIT_CODE |=>
        mapEffective == $past(hold)) else $error("commit did not apply holding copy");
    a_bad_key: assert property (key && accWdata != `BM_COMMIT_CODE |=>
        $stable(mapEffective)) else $error("bad key changed map");
    a_boot_mapped: assert property (rd && inBoot && bootMapped |=>
        selBoot && bootAddr == $past(bootExp)) else $error("boot decode wrong");
    a_absent_data: assert property (rd && !accFetch && inBoot && !bootMapped |=>
        rdataValid && rdata == `BOOT_ABSENT_DATA && !selBoot) else $error("absent read");
    a_absent_fetch: assert property (rd && accFetch && inBoot && !bootMapped |=>
        !selBoot && (BIG_FLASH ? selFlash : rdata == 8'hff)) else $error("absent fetch");
    a_flash_code: assert property (rd && accAddr >= `FLASH_CODE_LO |=>
        selFlash && flashAddr == $past(flashExp)) else $error("flash decode wrong");
    a_monitor_read: assert property (rd && !accFetch && accAddr == `BM_COMMIT_ADDR |=>
        rdataValid && rdata == mapEffective) else $error("monitor read wrong");
    a_reset_vector: assert property (resetEntryReq |=>
        vectorValid && vectorAddr == `VEC_RESET) else $error("reset entry wrong");
    a_stack_full: assert property (stackFull && !resetEntryReq |=> !vectorValid)
        else $error("vector taken with stack full");
    a_sfr_select: assert property (accValid && !accFetch && special_function_regs |=> selSfr)
        else $error("register region not selected");
    a_fetch_no_sfr: assert property (accValid && accFetch |=> !selSfr)
        else $error("fetch selected registers");

    c_mapped: cover property (bootMapped);
    c_boot_hit: cover property (selBoot);
    c_vector: cover property (vectorValid && !stackFull);
    c_absent: cover property (rdataValid && rdata == `BOOT_ABSENT_DATA && !bootMapped);
endmodule // boot_map_decode_asserts

bind boot_map_decode boot_map_decode_asserts #(.BIG_FLASH(BIG_FLASH)) u_chk (.*);

// *** sim/core_model.sv ***
// Purpose: CPU core stand-in issuing fetches and data accesses
// Assumes: a request is taken on the edge after it is driven
// Notes:   address and data scrambled while idle
`timescale 1ns/1ps

// ====================
// core model
module core_model (
    input  wire logic   clk_sys,
    output logic        accValid,
    output logic        accFetch,
    output logic        accWrite,
    output logic [15:0] accAddr,
    output logic [7:0]  accWdata
);
    initial begin
        accValid = 1'b0;
        accFetch = 1'b0;
        accWrite = 1'b0;
        accAddr = 16'h5a5a;
        accWdata = 8'ha5;
    end
    // callers only write assigned registers and, unless a bad key is wanted, the key itself
    task automatic acc(input logic f, input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        accValid = 1'b1;
        accFetch = f;
        accWrite = w;
        accAddr = a;
        accWdata = d;
        @(posedge clk_sys);
        #1;
        accValid = 1'b0;
        accAddr = ~a;
        accWdata = ~d;
    endtask
endmodule // core_model

// *** sim/boot_map_decode_test.sv ***
// Purpose: self-checking bench of the boot map decoder
// Assumes: main instance at default BIG_FLASH (trap opcode); a second one has big flash
// Notes:   random values from a fixed seed
`timescale 1ns/1ps
`include "boot_map_defs.svh"

// ====================
// bench
module boot_map_decode_test;
    logic        clk_sys, rst_b, serialProgMode, stackFull, resetEntryReq;
    logic        accValid, accFetch, accWrite, selSfr, selBoot, selFlash;
    logic        rdataValid, bootMapped, vectorValid;
    logic [15:0] accAddr, irqPending, irqEnable, vectorAddr, a;
    logic [7:0]  accWdata, bootRdata, flashRdata, rdata, mapEffective, v;
    logic [12:0] bootAddr;
    logic [13:0] flashAddr;
    logic        selFlashBig;
    logic [15:0] vecTab [16] = '{`VEC_SWI, `VEC_WDT, `VEC_WAKEUP, `VEC_TBT, `VEC_VOLT,
        `VEC_ADC, `VEC_RTC, `VEC_T8C0, `VEC_T8C1, `VEC_T16A0, `VEC_EXT0, `VEC_EXT1,
        `VEC_SER1RX, `VEC_SER1TX, `VEC_T8C2, `VEC_T8C3};
    logic [15:0] sfrTab [3] = '{16'h003f, 16'h0f1a, 16'h0e98};
    int          nFail, numChecks, seed, k;
    assign bootRdata = ~accAddr[7:0];
    assign flashRdata = accAddr[15:8];
    boot_map_decode DUT (.*);
    // large-flash variant shares the stimulus; only its flash select is watched
    boot_map_decode #(.BIG_FLASH(1'b1)) DUT_BIG (.*, .bootAddr(), .flashAddr(), .selSfr(),
        .selBoot(), .selFlash(selFlashBig), .rdataValid(), .rdata(), .mapEffective(),
        .bootMapped(), .vectorValid(), .vectorAddr());
    core_model cpu (.*);
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // only the lowest 2 Kbytes of boot content may appear in the map
    function automatic logic [12:0] boot_exp(input logic [15:0] x);
        return {2'b00, x[10:0]};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nFail++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input logic f, input logic [15:0] x, input logic [7:0] exp);
        cpu.acc(f, 1'b0, x, 8'h00);
        chk(rdataValid, 16'h1);
        chk(rdata, exp);
    endtask
    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask
    task end_of_test;
        if (nFail == 0 && numChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        nFail++;
        end_of_test;
    end
    initial begin
        seed = 32'h157c9c6e;
        rst_b = 1'b0;
        {serialProgMode, stackFull, resetEntryReq, irqPending, irqEnable} = '0;
        repeat (4) tick;
        chk(vectorAddr, `VEC_RESET);
        rst_b = 1'b1;
        chk(mapEffective, `BM_CTRL_RESET);
        rdc(1'b0, `BM_CTRL_ADDR, `BM_CTRL_RESET);
        foreach (sfrTab[j]) begin
            a = sfrTab[j];
            rdc(1'b0, 16'h1000 | a[10:0], `BOOT_ABSENT_DATA);
            rdc(1'b1, 16'h17ff - a[10:0], 8'hff);
            chk(selBoot, 16'h0);
            chk(selFlashBig, 16'h1);
            cpu.acc(1'b0, 1'b0, a, 8'h00);
            chk(selSfr, 16'h1);
        end
        v = 8'($random(seed)) | 8'h10;
        cpu.acc(1'b0, 1'b1, `BM_CTRL_ADDR, v);
        rdc(1'b0, `BM_COMMIT_ADDR, `BM_CTRL_RESET);
        cpu.acc(1'b0, 1'b1, `BM_COMMIT_ADDR, 8'hd4 ^ (8'($random(seed)) & 8'hfe));
        chk(mapEffective, `BM_CTRL_RESET);
        rdc(1'b0, `BM_CTRL_ADDR, v);
        cpu.acc(1'b0, 1'b1, `BM_COMMIT_ADDR, `BM_COMMIT_CODE);
        chk(bootMapped, 16'h1);
        chk(mapEffective, v);
        rdc(1'b0, `BM_COMMIT_ADDR, v);
        for (k = 0; k < 16; k++) begin
            a = 16'h1000 | (16'($random(seed)) & 16'h07ff);
            serialProgMode = 1'($random(seed));
            cpu.acc(k[0], 1'b0, a, 8'h00);
            chk(selBoot, 16'h1);
            chk(bootAddr, boot_exp(a));
            a = 16'h8000 | 16'($random(seed));
            cpu.acc(k[1], 1'b0, a, 8'h00);
            chk(selFlash, 16'h1);
            chk(flashAddr, a[13:0]);
            // source k pending, nothing of higher priority; others' enables random
            irqEnable = 16'($random(seed)) | (16'h0001 << k);
            irqPending = 16'($random(seed) | 1) << k;
            tick;
            chk(vectorValid, 16'h1);
            chk(vectorAddr, vecTab[k]);
        end
        stackFull = 1'b1;
        tick;
        chk(vectorValid, 16'h0);
        {stackFull, irqEnable} = '0;
        tick;
        chk(vectorValid, 16'h0);
        resetEntryReq = 1'b1;
        tick;
        chk(vectorAddr, `VEC_RESET);
        rst_b = 1'b0;
        tick;
        chk(bootMapped, 16'h0);
        chk(mapEffective, `BM_CTRL_RESET);
        rst_b = 1'b1;
        resetEntryReq = 1'b0;
        rdc(1'b0, `BM_CTRL_ADDR, `BM_CTRL_RESET);
        end_of_test;
    end
endmodule // boot_map_decode_test
